// *** bench/dual_serial_ports_baud_gen_bench.sv ***
module dual_serial_ports_baud_gen_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [1:0] rsp;
   wire logic awready, wready, bvalid, arready, rvalid, tx0, rx1, tx1, m0_out, m0_oe;
   wire logic [1:0] rresp, bresp;
   wire logic [31:0] rdata;
   int n_mismatch = 0;
   int compares = 0;
   dual_serial_ports dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .timer1_overflow(1'b0), .ser0_rx_pin_in(1'b1), .ser0_rx_pin_out(m0_out),
      .ser0_rx_pin_oe(m0_oe), .ser0_tx_pin(tx0), .ser1_rx_pin(rx1), .ser1_tx_pin(tx1));
   remote_serial far (.aclk(aclk), .line(rx1));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait, a spent limit ends the run
   task automatic tmo(input int n);
      if (n > 400) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         tmo(++n);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk("bresp", 32'h0, {30'h0, bresp});
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      int n = 0;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         tmo(++n);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // reload reset value and an unmapped read
   task automatic t_regs;
      rdr(serial_pkg::ADDR_S0_RELOAD_LOW);
      chk("reload low", 32'hD9, rd);
      rdr(serial_pkg::ADDR_S0_RELOAD_HIGH);
      chk("reload high", 32'h3, rd);
      rdr(8'h20);
      chk("unmapped resp", 32'h2, {30'h0, rsp});
      $display("test regs done");
   endtask
   // mode 0 transmit, data on receive pin at each rising shift clock
   task automatic t_m0;
      int n = 0;
      wr(serial_pkg::ADDR_S0_CTRL, 32'h00);
      wr(serial_pkg::ADDR_S0_DATA, 32'h5A);
      for (int i = 0; i < 8; i++) begin
         while (tx0 !== 1'b0) begin
            @(posedge aclk);
            tmo(++n);
         end
         while (tx0 !== 1'b1) begin
            @(posedge aclk);
            tmo(++n);
         end
         chk("m0 oe", 32'h1, {31'h0, m0_oe});
         chk("m0 bit", {31'h0, i[0] ^ i[2] ? 1'b1 : 1'b0}, {31'h0, m0_out});
      end
      repeat (4) @(posedge aclk);
      rdr(serial_pkg::ADDR_S0_CTRL);
      chk("m0 tx done", 32'h2, rd & 32'h2);
      $display("test m0 done");
   endtask
   // mode 2, ninth bit set, 64 cycles per bit
   task automatic t_m2;
      logic [10:0] f = {2'h3, 8'hA5, 1'h0};
      int n = 0;
      wr(serial_pkg::ADDR_S0_CTRL, 32'h88);
      wr(serial_pkg::ADDR_S0_DATA, 32'hA5);
      while (tx0 !== 1'b0) begin
         @(posedge aclk);
         tmo(++n);
      end
      repeat (32) @(posedge aclk);
      for (int i = 0; i < 11; i++) begin
         chk("s0 bit", {31'h0, f[i]}, {31'h0, tx0});
         repeat (64) @(posedge aclk);
      end
      $display("test m2 done");
   endtask
   // interface 1 mode B receive at reload 0x3FF, 32 cycles per bit
   task automatic t_s1;
      wr(serial_pkg::ADDR_S1_RELOAD, 32'h3FF);
      wr(serial_pkg::ADDR_S1_CTRL, 32'h90);
      // the new reload only takes effect at the next generator wrap
      repeat (200) @(posedge aclk);
      chk("s1 tx idle", 32'h1, {31'h0, tx1});
      far.send({2'h1, 8'h3C, 1'h0}, 10, 32);
      repeat (64) @(posedge aclk);
      rdr(serial_pkg::ADDR_S1_DATA);
      chk("s1 data", 32'h3C, rd);
      rdr(serial_pkg::ADDR_S1_CTRL);
      chk("s1 flags", 32'h5, rd & 32'h5);
      $display("test s1 done");
   endtask
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_m0();
      t_m2();
      t_s1();
      results();
   end
endmodule // dual_serial_ports_baud_gen_bench

// *** bench/remote_serial.sv ***
// far-side async transmitter, line idles high
module remote_serial (
   input wire logic aclk,
   output logic line
);
   timeunit 1ns;
   timeprecision 100ps;
   initial line = 1'b1;
   // one frame lsb first, each bit held for period cycles
   task automatic send(input logic [10:0] f, input int bits, input int period);
      for (int i = 0; i < bits; i++) begin
         line <= f[i];
         repeat (period) @(posedge aclk);
      end
      line <= 1'b1;
   endtask
endmodule // remote_serial

// *** pkg/serial_pkg.sv ***
package serial_pkg;

   // register bus
   localparam int ADDR_WIDTH = 8;
   localparam logic [7:0] ADDR_S0_CTRL = 8'h00;
   localparam logic [7:0] ADDR_S0_DATA = 8'h04;
   localparam logic [7:0] ADDR_S0_RELOAD_LOW = 8'h08;
   localparam logic [7:0] ADDR_S0_RELOAD_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_BAUD_CFG = 8'h10;
   localparam logic [7:0] ADDR_S1_CTRL = 8'h14;
   localparam logic [7:0] ADDR_S1_DATA = 8'h18;
   localparam logic [7:0] ADDR_S1_RELOAD = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // control register fields, shared by both interfaces except the mode bits; then the baud config bits
   localparam int CTRL_MODE_LSB = 6;
   localparam int CTRL_S1_MODE_B = 7;
   localparam int CTRL_BUSY = 5;
   localparam int CTRL_RX_EN = 4;
   localparam int CTRL_TX9 = 3;
   localparam int CTRL_RX9 = 2;
   localparam int CTRL_TX_DONE = 1;
   localparam int CTRL_RX_DONE = 0;
   localparam int BAUD_DOUBLER_BIT = 0;
   localparam int BAUD_GEN_SEL_BIT = 1;

   // reset values
   localparam logic [9:0] S0_RELOAD_RESET = 10'h3D9;
   localparam logic [9:0] S1_RELOAD_RESET = 10'h3B2;
   localparam logic [9:0] RELOAD_TOP = 10'h3FF;
   localparam logic BAUD_DOUBLER_RESET = 1'h0;
   localparam logic GEN_SEL_RESET = 1'h1;

   // timing counts in oscillator cycles, sample ticks per bit and bits per frame
   localparam logic [3:0] M0_PHASE_LAST = 4'hB;
   localparam logic [3:0] M0_PHASE_HIGH = 4'h6;
   localparam logic [1:0] PRESCALE_LAST_DOUBLED = 2'h1;
   localparam logic [1:0] PRESCALE_LAST_NORMAL = 2'h3;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [3:0] FRAME_LEN_EIGHT = 4'hA;
   localparam logic [3:0] FRAME_LEN_NINE = 4'hB;

   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_UART8 = 2'b01,
      MODE_UART9_FIXED = 2'b10,
      MODE_UART9_VAR = 2'b11
   } ser0_mode_t;

   typedef enum logic [1:0] {
      SHIFT_IDLE = 2'b00,
      SHIFT_TX = 2'b01,
      SHIFT_RX = 2'b10
   } shift_state_t;

   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } serial_word_t;

endpackage

// *** rtl/async_serial_engine.sv ***
// one asynchronous transmitter and receiver, 16 sample ticks per bit
module async_serial_engine (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sample_tick,
   input wire logic nine_bit,
   input wire logic rx_enable,
   input wire logic tx_start,
   input wire serial_pkg::serial_word_t tx_word,
   input wire logic rx_line,
   output logic tx_line,
   output logic tx_busy,
   output logic tx_done,
   output logic rx_done,
   output serial_pkg::serial_word_t rx_word
);
   logic [10:0] tx_shift;
   logic [3:0] tx_left;
   logic [3:0] tx_cnt;
   logic [3:0] rx_left;
   logic [3:0] rx_cnt;
   logic [9:0] rx_shift;
   logic rx_busy;

   // frame build and receive decode
   wire [10:0] tx_frame = nine_bit ? {1'b1, tx_word.ninth, tx_word.data, 1'b0}
                                   : {2'b11, tx_word.data, 1'b0};
   wire [3:0] frame_len = nine_bit ? serial_pkg::FRAME_LEN_NINE : serial_pkg::FRAME_LEN_EIGHT;
   wire bit_end = tx_cnt == serial_pkg::TICK_LAST;
   wire rx_mid = sample_tick && rx_busy && rx_cnt == serial_pkg::TICK_MID;
   wire rx_first = rx_left == frame_len;
   wire rx_last = rx_left == 4'h1;
   wire [7:0] rx_data_nine = rx_shift[8:1];
   wire [7:0] rx_data_next = nine_bit ? rx_data_nine : rx_shift[9:2];
   wire rx_ninth_next = nine_bit ? rx_shift[9] : rx_line;
   wire tx_ninth_in = tx_word.ninth;
   assign tx_line = tx_shift[0];

   // transmitter: shift out lsb first, idle line high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_shift <= '1;
         tx_left <= 4'h0;
         tx_cnt <= 4'h0;
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (!tx_busy && tx_start) begin
            tx_shift <= tx_frame;
            tx_left <= frame_len;
            tx_cnt <= 4'h0;
            tx_busy <= 1'b1;
         end else if (tx_busy && sample_tick) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (bit_end) begin
               tx_shift <= {1'b1, tx_shift[10:1]};
               tx_left <= tx_left - 4'h1;
               if (tx_left == 4'h1) begin
                  tx_busy <= 1'b0;
                  tx_done <= 1'b1;
               end
            end
         end
      end
   end

   // receiver: start edge, mid-bit sampling, false start rejected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_busy <= 1'b0;
         rx_cnt <= 4'h0;
         rx_left <= 4'h0;
         rx_shift <= '0;
         rx_done <= 1'b0;
         rx_word <= '0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (rx_enable && sample_tick && !rx_line) begin
               rx_busy <= 1'b1;
               rx_cnt <= 4'h1;
               rx_left <= frame_len;
            end
         end else if (sample_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_mid) begin
               rx_shift <= {rx_line, rx_shift[9:1]};
               rx_left <= rx_left - 4'h1;
               if (rx_first && rx_line) begin
                  rx_busy <= 1'b0;
               end else if (rx_last) begin
                  rx_busy <= 1'b0;
                  rx_done <= 1'b1;
                  rx_word <= {rx_ninth_next, rx_data_next};
               end
            end
         end
      end
   end

   property p_start_low;
      @(posedge aclk) disable iff (!aresetn) $rose(tx_busy) |-> !tx_line;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_stop_high;
      @(posedge aclk) disable iff (!aresetn) $fell(tx_busy) |-> tx_line ##1 tx_line;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("line not high after frame");

   property p_ninth_loaded;
      @(posedge aclk) disable iff (!aresetn)
         (tx_start && !tx_busy && nine_bit) |=> tx_shift[9] == $past(tx_ninth_in);
   endproperty
   a_ninth_loaded: assert property (p_ninth_loaded) else $error("ninth bit not framed");

   property p_stop_kept;
      @(posedge aclk) disable iff (!aresetn)
         (rx_mid && rx_last && !rx_first && !nine_bit) |=> rx_done && rx_word.ninth == $past(rx_line);
   endproperty
   a_stop_kept: assert property (p_stop_kept) else $error("stop bit not stored");

   property p_nine_rx;
      @(posedge aclk) disable iff (!aresetn)
         (rx_mid && rx_last && nine_bit) |=> rx_word.data == $past(rx_data_nine);
   endproperty
   a_nine_rx: assert property (p_nine_rx) else $error("nine-bit data misplaced");

endmodule // async_serial_engine

// *** rtl/dual_serial_ports.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
module dual_serial_ports (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [serial_pkg::ADDR_WIDTH-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [serial_pkg::ADDR_WIDTH-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic timer1_overflow,
   input wire logic ser0_rx_pin_in,
   output logic ser0_rx_pin_out,
   output logic ser0_rx_pin_oe,
   output logic ser0_tx_pin,
   input wire logic ser1_rx_pin,
   output logic ser1_tx_pin
);
   logic aw_held, w_held, wr_lane0;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   serial_pkg::ser0_mode_t s0_mode;
   logic s0_rx_en, ser0_tx_ninth_bit, ser0_rx_ninth_bit, s0_tx_flag, s0_rx_flag;
   logic [7:0] s0_rx_data;
   logic [9:0] ser0_reload_value, gen0, gen1, ser1_reload_value;
   logic baud_doubler, fixed_baud_prescaler, t1_phase, s1_pre;
   logic s1_mode_b, s1_rx_en, ser1_tx_ninth_bit, ser1_rx_ninth_bit, s1_tx_flag, s1_rx_flag;
   logic [7:0] s1_rx_data;
   logic [1:0] pre_cnt;
   serial_pkg::shift_state_t m0_state;
   logic [3:0] m0_phase;
   logic [2:0] m0_bit;
   logic [7:0] m0_shift;
   logic eng0_tx_line, eng0_tx_busy, eng0_tx_done, eng0_rx_done;
   logic eng1_tx_line, eng1_tx_busy, eng1_tx_done, eng1_rx_done;
   serial_pkg::serial_word_t eng0_rx_word, eng1_rx_word;

   // write channel handshake: address and data in either order
   wire aw_hs = awvalid && awready;
   wire w_hs = wvalid && wready;
   wire wr_fire = aw_held && w_held && !bvalid;
   wire next_aw_held = (aw_held || aw_hs) && !wr_fire;
   wire next_w_held = (w_held || w_hs) && !wr_fire;
   wire next_bvalid = wr_fire || (bvalid && !bready);
   wire ar_hs = arvalid && arready;
   wire next_rvalid = ar_hs || (rvalid && !rready);

   // write decode, the byte lane 0 strobe gates every register write
   wire wr_en = wr_fire && wr_lane0;
   wire wr_s0_ctrl = wr_en && wr_addr == serial_pkg::ADDR_S0_CTRL;
   wire wr_s0_data = wr_en && wr_addr == serial_pkg::ADDR_S0_DATA;
   wire wr_s0_rell = wr_en && wr_addr == serial_pkg::ADDR_S0_RELOAD_LOW;
   wire wr_s0_relh = wr_en && wr_addr == serial_pkg::ADDR_S0_RELOAD_HIGH;
   wire wr_baud = wr_en && wr_addr == serial_pkg::ADDR_BAUD_CFG;
   wire wr_s1_ctrl = wr_en && wr_addr == serial_pkg::ADDR_S1_CTRL;
   wire wr_s1_data = wr_en && wr_addr == serial_pkg::ADDR_S1_DATA;
   wire wr_s1_rel = wr_en && wr_addr == serial_pkg::ADDR_S1_RELOAD;
   wire wr_mapped = wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0;
   wire rd_mapped = araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0;

   // read mux
   wire m0_active = m0_state != serial_pkg::SHIFT_IDLE;
   wire [7:0] s0_ctrl_rd = {s0_mode, eng0_tx_busy | m0_active, s0_rx_en, ser0_tx_ninth_bit,
                            ser0_rx_ninth_bit, s0_tx_flag, s0_rx_flag};
   wire [7:0] s1_ctrl_rd = {s1_mode_b, 1'b0, eng1_tx_busy, s1_rx_en, ser1_tx_ninth_bit,
                            ser1_rx_ninth_bit, s1_tx_flag, s1_rx_flag};
   wire [9:0] rd_word =
      (araddr == serial_pkg::ADDR_S0_CTRL) ? {2'h0, s0_ctrl_rd} :
      (araddr == serial_pkg::ADDR_S0_DATA) ? {2'h0, s0_rx_data} :
      (araddr == serial_pkg::ADDR_S0_RELOAD_LOW) ? {2'h0, ser0_reload_value[7:0]} :
      (araddr == serial_pkg::ADDR_S0_RELOAD_HIGH) ? {8'h00, ser0_reload_value[9:8]} :
      (araddr == serial_pkg::ADDR_BAUD_CFG) ? {8'h00, fixed_baud_prescaler, baud_doubler} :
      (araddr == serial_pkg::ADDR_S1_CTRL) ? {2'h0, s1_ctrl_rd} :
      (araddr == serial_pkg::ADDR_S1_DATA) ? {2'h0, s1_rx_data} :
      (araddr == serial_pkg::ADDR_S1_RELOAD) ? ser1_reload_value : 10'h000;

   // bus slave registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_held, w_held, awready, wready, bvalid, arready, rvalid, wr_lane0} <= 8'h00;
         bresp <= serial_pkg::RESP_OKAY;
         rresp <= serial_pkg::RESP_OKAY;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         rdata <= 32'h0000_0000;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awready <= !next_aw_held && !next_bvalid;
         wready <= !next_w_held && !next_bvalid;
         bvalid <= next_bvalid;
         arready <= !next_rvalid;
         rvalid <= next_rvalid;
         if (aw_hs) wr_addr <= awaddr;
         if (w_hs) begin
            wr_data <= wdata;
            wr_lane0 <= wstrb[0];
         end
         if (wr_fire) bresp <= wr_mapped ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
         if (ar_hs) begin
            rdata <= {22'h00_0000, rd_word};
            rresp <= rd_mapped ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
         end
      end
   end

   // baud sources
   wire m0_mode = s0_mode == serial_pkg::MODE_SHIFT;
   wire [1:0] pre_last = baud_doubler ? serial_pkg::PRESCALE_LAST_DOUBLED
                                      : serial_pkg::PRESCALE_LAST_NORMAL;
   wire pre_tick = pre_cnt == pre_last;
   wire gen0_wrap = gen0 == serial_pkg::RELOAD_TOP;
   wire gen0_tick = pre_tick && gen0_wrap;
   wire t1_tick = timer1_overflow && (baud_doubler || t1_phase);
   wire s0_var_tick = fixed_baud_prescaler ? gen0_tick : t1_tick;
   wire s0_tick = (s0_mode == serial_pkg::MODE_UART9_FIXED) ? pre_tick : s0_var_tick;
   wire gen1_wrap = gen1 == serial_pkg::RELOAD_TOP;
   wire s1_tick = s1_pre && gen1_wrap;

   // prescalers and reloadable generators
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= 2'h0;
         gen0 <= serial_pkg::S0_RELOAD_RESET;
         gen1 <= serial_pkg::S1_RELOAD_RESET;
         t1_phase <= 1'b0;
         s1_pre <= 1'b0;
      end else begin
         pre_cnt <= pre_tick ? 2'h0 : pre_cnt + 2'h1;
         if (pre_tick) gen0 <= gen0_wrap ? ser0_reload_value : gen0 + 10'h001;
         if (timer1_overflow) t1_phase <= !t1_phase;
         s1_pre <= !s1_pre;
         if (s1_pre) gen1 <= gen1_wrap ? ser1_reload_value : gen1 + 10'h001;
      end
   end

   // shift mode sequencing
   wire m0_tx_go = wr_s0_data && m0_mode && !m0_active;
   wire m0_rx_go = m0_mode && !m0_active && s0_rx_en && !s0_rx_flag && !m0_tx_go;
   wire phase_end = m0_phase == serial_pkg::M0_PHASE_LAST;
   wire m0_last = m0_bit == 3'h7;
   wire m0_in = (m0_state == serial_pkg::SHIFT_RX) && ser0_rx_pin_in;
   wire m0_tx_done = m0_state == serial_pkg::SHIFT_TX && phase_end && m0_last;
   wire m0_rx_done = m0_state == serial_pkg::SHIFT_RX && phase_end && m0_last;
   wire m0_clock = !m0_active || m0_phase >= serial_pkg::M0_PHASE_HIGH;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         m0_state <= serial_pkg::SHIFT_IDLE;
         m0_phase <= 4'h0;
         m0_bit <= 3'h0;
         m0_shift <= 8'h00;
      end else begin
         unique case (m0_state)
            serial_pkg::SHIFT_IDLE: begin
               m0_phase <= 4'h0;
               m0_bit <= 3'h0;
               if (m0_tx_go) begin
                  m0_state <= serial_pkg::SHIFT_TX;
                  m0_shift <= wr_data[7:0];
               end else if (m0_rx_go) begin
                  m0_state <= serial_pkg::SHIFT_RX;
               end
            end
            serial_pkg::SHIFT_TX, serial_pkg::SHIFT_RX: begin
               m0_phase <= phase_end ? 4'h0 : m0_phase + 4'h1;
               if (phase_end) begin
                  m0_shift <= {m0_in, m0_shift[7:1]};
                  m0_bit <= m0_bit + 3'h1;
                  if (m0_last) m0_state <= serial_pkg::SHIFT_IDLE;
               end
            end
            default: m0_state <= serial_pkg::SHIFT_IDLE;
         endcase
      end
   end

   // registered pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ser0_tx_pin <= 1'b1;
         ser0_rx_pin_out <= 1'b0;
         ser0_rx_pin_oe <= 1'b0;
         ser1_tx_pin <= 1'b1;
      end else begin
         ser0_tx_pin <= m0_mode ? m0_clock : eng0_tx_line;
         ser0_rx_pin_out <= m0_shift[0];
         ser0_rx_pin_oe <= m0_state == serial_pkg::SHIFT_TX;
         ser1_tx_pin <= eng1_tx_line;
      end
   end

   // software registers and hardware flags, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s0_mode <= serial_pkg::MODE_SHIFT;
         {s0_rx_en, ser0_tx_ninth_bit, ser0_rx_ninth_bit, s0_tx_flag, s0_rx_flag} <= 5'h00;
         {s1_mode_b, s1_rx_en, ser1_tx_ninth_bit, ser1_rx_ninth_bit, s1_tx_flag, s1_rx_flag} <= 6'h00;
         s0_rx_data <= 8'h00;
         s1_rx_data <= 8'h00;
         ser0_reload_value <= serial_pkg::S0_RELOAD_RESET;
         ser1_reload_value <= serial_pkg::S1_RELOAD_RESET;
         baud_doubler <= serial_pkg::BAUD_DOUBLER_RESET;
         fixed_baud_prescaler <= serial_pkg::GEN_SEL_RESET;
      end else begin
         if (wr_s0_ctrl) begin
            s0_mode <= serial_pkg::ser0_mode_t'(wr_data[serial_pkg::CTRL_MODE_LSB +: 2]);
            s0_rx_en <= wr_data[serial_pkg::CTRL_RX_EN];
            ser0_tx_ninth_bit <= wr_data[serial_pkg::CTRL_TX9];
         end
         if (wr_s1_ctrl) begin
            s1_mode_b <= wr_data[serial_pkg::CTRL_S1_MODE_B];
            s1_rx_en <= wr_data[serial_pkg::CTRL_RX_EN];
            ser1_tx_ninth_bit <= wr_data[serial_pkg::CTRL_TX9];
         end
         if (wr_s0_rell) ser0_reload_value[7:0] <= wr_data[7:0];
         if (wr_s0_relh) ser0_reload_value[9:8] <= wr_data[1:0];
         if (wr_s1_rel) ser1_reload_value <= wr_data[9:0];
         if (wr_baud) begin
            baud_doubler <= wr_data[serial_pkg::BAUD_DOUBLER_BIT];
            fixed_baud_prescaler <= wr_data[serial_pkg::BAUD_GEN_SEL_BIT];
         end
         s0_tx_flag <= m0_tx_done | eng0_tx_done
                       | (s0_tx_flag & ~(wr_s0_ctrl & wr_data[serial_pkg::CTRL_TX_DONE]));
         s0_rx_flag <= m0_rx_done | eng0_rx_done
                       | (s0_rx_flag & ~(wr_s0_ctrl & wr_data[serial_pkg::CTRL_RX_DONE]));
         s1_tx_flag <= eng1_tx_done
                       | (s1_tx_flag & ~(wr_s1_ctrl & wr_data[serial_pkg::CTRL_TX_DONE]));
         s1_rx_flag <= eng1_rx_done
                       | (s1_rx_flag & ~(wr_s1_ctrl & wr_data[serial_pkg::CTRL_RX_DONE]));
         if (m0_rx_done) s0_rx_data <= {ser0_rx_pin_in, m0_shift[7:1]};
         if (eng0_rx_done) begin
            s0_rx_data <= eng0_rx_word.data;
            ser0_rx_ninth_bit <= eng0_rx_word.ninth;
         end
         if (eng1_rx_done) begin
            s1_rx_data <= eng1_rx_word.data;
            ser1_rx_ninth_bit <= eng1_rx_word.ninth;
         end
      end
   end

   // asynchronous engines
   async_serial_engine u_eng0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_tick(s0_tick),
      .nine_bit(s0_mode[1]),
      .rx_enable(s0_rx_en && !m0_mode),
      .tx_start(wr_s0_data && !m0_mode),
      .tx_word({ser0_tx_ninth_bit, wr_data[7:0]}),
      .rx_line(ser0_rx_pin_in),
      .tx_line(eng0_tx_line),
      .tx_busy(eng0_tx_busy),
      .tx_done(eng0_tx_done),
      .rx_done(eng0_rx_done),
      .rx_word(eng0_rx_word)
   );

   async_serial_engine u_eng1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_tick(s1_tick),
      .nine_bit(!s1_mode_b),
      .rx_enable(s1_rx_en),
      .tx_start(wr_s1_data),
      .tx_word({ser1_tx_ninth_bit, wr_data[7:0]}),
      .rx_line(ser1_rx_pin),
      .tx_line(eng1_tx_line),
      .tx_busy(eng1_tx_busy),
      .tx_done(eng1_tx_done),
      .rx_done(eng1_rx_done),
      .rx_word(eng1_rx_word)
   );

   property p_m0_clock_high;
      @(posedge aclk) disable iff (!aresetn)
         (m0_state == serial_pkg::SHIFT_TX && $rose(ser0_tx_pin)) |-> ser0_tx_pin [*6];
   endproperty
   a_m0_clock_high: assert property (p_m0_clock_high) else $error("shift clock high time wrong");

   property p_m0_drive;
      @(posedge aclk) disable iff (!aresetn)
         m0_active |=> ser0_rx_pin_oe == ($past(m0_state) == serial_pkg::SHIFT_TX);
   endproperty
   a_m0_drive: assert property (p_m0_drive) else $error("receive pin drive wrong");

   property p_mode2_rate;
      @(posedge aclk) disable iff (!aresetn)
         (s0_mode == serial_pkg::MODE_UART9_FIXED && baud_doubler && !wr_baud && s0_tick)
            |=> !s0_tick ##1 s0_tick;
   endproperty
   a_mode2_rate: assert property (p_mode2_rate) else $error("mode 2 doubled rate wrong");

   property p_reload_reset;
      @(posedge aclk) disable iff (!aresetn)
         $rose(aresetn) |-> ser0_reload_value == serial_pkg::S0_RELOAD_RESET;
   endproperty
   a_reload_reset: assert property (p_reload_reset) else $error("reload reset value wrong");

   property p_gen0_reload;
      @(posedge aclk) disable iff (!aresetn) gen0_tick |=> gen0 == $past(ser0_reload_value);
   endproperty
   a_gen0_reload: assert property (p_gen0_reload) else $error("generator 0 reload missed");

   property p_gen1_step;
      @(posedge aclk) disable iff (!aresetn) (gen1 != $past(gen1)) |=> $stable(gen1);
   endproperty
   a_gen1_step: assert property (p_gen1_step) else $error("generator 1 prescale wrong");

   c_m0_tx: cover property (@(posedge aclk) disable iff (!aresetn) m0_tx_done);
   c_s0_rx: cover property (@(posedge aclk) disable iff (!aresetn) eng0_rx_done);
   c_s1_rx: cover property (@(posedge aclk) disable iff (!aresetn) eng1_rx_done && !s1_mode_b);
   c_s0_tx: cover property (@(posedge aclk) disable iff (!aresetn) eng0_tx_done);

endmodule // dual_serial_ports
